// ---- dic_top.sv ----
// Purpose: Digital input conditioner with Wishbone register access
// Assumes: Classic Wishbone, one answer per request
// Notes:   Scan read of the scan register clears capture latches
`timescale 1ns/1ps
module dic_top
  import dic_pkg::*;
#(
  parameter int       DC_CYC    = DC_UNIT_CYC,
  parameter int       MS_TICK   = MS_CYC,
  parameter bit       MODEL_32  = 1'b1,
  parameter bit       IEC_TYPE  = 1'b0
)(
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [7:0]       ADR_I,
  input  wire logic [31:0]      DAT_I,
  output logic [31:0]           DAT_O,
  input  wire logic             WE_I,
  input  wire logic [3:0]       SEL_I,
  input  wire logic             STB_I,
  input  wire logic             CYC_I,
  output logic                  ACK_O,
  input  wire logic [NCH-1:0]   INPUT_CHANNEL,
  input  wire logic [3:0]       MOD_ERR,
  output logic                  ERR_LED,
  output logic                  FAIL_STAT,
  output logic [NCH-1:0]        CH_LED,
  output logic [NCH-1:0]        APP_VALUE,
  output logic [NCH-1:0]        EVENT_TRIG,
  output logic                  TAG_VALID,
  output logic [4:0]            TAG_CHAN,
  output logic                  TAG_LEVEL,
  output logic [31:0]           TAG_TIME,
  output logic                  POWER_DOWN
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0]       ctrl;
  logic [7:0]       dc_filt;
  logic [7:0]       cnt_filt;
  logic [7:0]       dc_tfilt;
  logic [7:0]       cnt_tfilt;
  logic [NCH-1:0]   capen;
  logic [NCH-1:0]   cnten;
  logic [NCH-1:0]   tagen;
  logic [NCH-1:0]   psel;
  logic [NCH-1:0]   pval;
  logic [NCH-1:0]   mask;
  logic [NCH-1:0]   cap_pend;
  logic [NCH-1:0]   cap_val;
  logic [NCH-1:0]   hold_last_reading;
  logic [NCH-1:0]   tag_pend;
  logic [DIV_W-1:0] dc_div;
  logic [DIV_W-1:0] cnt_div;
  logic [DIV_W-1:0] ms_div;
  logic             tick_dc;
  logic             tick_cnt;
  logic [31:0]      ms_time;
  logic [NCH-1:0]   level;
  logic [NCH-1:0]   chg;
  logic [CNT_W-1:0] count [NCH];
  logic [NCH-1:0]   ch_ok;
  logic [NCH-1:0]   cnt_ok;
  logic [31:0]      rdata;
  logic [4:0]       grant_idx;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire ac_mode = ctrl[CTRL_AC] && !IEC_TYPE;
  wire sleep   = ctrl[CTRL_SLEEP];
  wire freeze  = ctrl[CTRL_FREEZE];
  wire test    = ctrl[CTRL_TEST];
  wire run     = !sleep;
  wire failed  = |MOD_ERR;
  wire [7:0] dc_lim  = test ? dc_tfilt : dc_filt;
  wire [7:0] cnt_lim = test ? cnt_tfilt : cnt_filt;
  wire [7:0] dc_wr   = DAT_I[7:0] > DC_FILT_MAX ? DC_FILT_MAX : DAT_I[7:0];
  wire [NCH-1:0] cap_act = capen & {NCH{!ac_mode}} & ch_ok;
  wire [NCH-1:0] cnt_act = cnten & {NCH{!ac_mode}} & cnt_ok;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req      = CYC_I && STB_I;
  wire wr       = req && ACK_O && WE_I;
  wire scan_rd  = req && ACK_O && !WE_I && ADR_I == REG_SCAN;
  wire [7:0] cnt_off = ADR_I - {CNT_REGION, 6'h00};
  wire cnt_sel  = !cnt_off[7];
  wire [NCH-1:0] next_cap_set = chg & cap_act & (~cap_pend | {NCH{scan_rd}});
  wire [NCH-1:0] live_view = (cap_pend & cap_act & cap_val)
                           | (~(cap_pend & cap_act) & level);
  wire [NCH-1:0] fail_view = (psel & pval) | (~psel & hold_last_reading);
  wire [NCH-1:0] norm_view = (mask & pval) | (~mask & live_view);
  wire force_pdv = sleep || freeze;
  wire [NCH-1:0] next_app = force_pdv ? pval
                          : failed ? fail_view : norm_view;
  wire [NCH-1:0] grant = tag_pend & (~tag_pend + 32'h1);
  wire [NCH-1:0] next_tag_set = chg & tagen & ch_ok;

  always_comb begin
    grant_idx = 5'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (grant[i]) begin
        grant_idx = 5'(i);
      end
    end
  end

  always_comb begin
    rdata = 32'h0;
    if (cnt_sel) begin
      rdata = {16'h0, count[cnt_off[6:2]]};
    end else begin
      case (ADR_I)
        REG_CTRL:  rdata = {28'h0, ctrl};
        REG_FILT:  rdata = {16'h0, cnt_filt, dc_filt};
        REG_TFILT: rdata = {16'h0, cnt_tfilt, dc_tfilt};
        REG_CAPEN: rdata = capen;
        REG_CNTEN: rdata = cnten;
        REG_TAGEN: rdata = tagen;
        REG_PSEL:  rdata = psel;
        REG_PVAL:  rdata = pval;
        REG_MASK:  rdata = mask;
        REG_SCAN:  rdata = APP_VALUE;
        REG_LIVE:  rdata = level;
        REG_STAT:  rdata = {27'h0, MOD_ERR, FAIL_STAT};
        default:   rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign ch_ok[g]  = MODEL_32 || g < NCH_SMALL;
      assign cnt_ok[g] = MODEL_32 ? g < CNT_CH_LARGE : g < NCH_SMALL;
      dic_chan u_ch (
        .clk      (CLK),
        .rst      (RST),
        .raw_pin  (INPUT_CHANNEL[g] && ch_ok[g]),
        .run      (run),
        .bypass   (ac_mode),
        .cnt_mode (cnt_act[g]),
        .tick_dc  (tick_dc),
        .tick_cnt (tick_cnt),
        .dc_lim   (dc_lim),
        .cnt_lim  (cnt_lim),
        .level    (level[g]),
        .chg      (chg[g]),
        .count    (count[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      dc_div   <= '0;
      cnt_div  <= '0;
      ms_div   <= '0;
      tick_dc  <= 1'b0;
      tick_cnt <= 1'b0;
      ms_time  <= 32'h0;
    end else begin
      tick_dc  <= dc_div == DIV_W'(DC_CYC - 1);
      tick_cnt <= cnt_div == DIV_W'(CNT_UNIT_CYC - 1);
      dc_div   <= dc_div == DIV_W'(DC_CYC - 1) ? '0 : dc_div + 1'b1;
      cnt_div  <= cnt_div == DIV_W'(CNT_UNIT_CYC - 1) ? '0 : cnt_div + 1'b1;
      ms_div   <= ms_div == DIV_W'(MS_TICK - 1) ? '0 : ms_div + 1'b1;
      if (ms_div == DIV_W'(MS_TICK - 1)) begin
        ms_time <= ms_time + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Bus slave and configuration
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      ACK_O     <= 1'b0;
      DAT_O     <= 32'h0;
      ctrl      <= 4'h0;
      dc_filt   <= DC_FILT_RST;
      cnt_filt  <= CNT_FILT_RST;
      dc_tfilt  <= DC_FILT_RST;
      cnt_tfilt <= CNT_FILT_RST;
      capen     <= '0;
      cnten     <= '0;
      tagen     <= '0;
      psel      <= '0;
      pval      <= '0;
      mask      <= '0;
    end else begin
      ACK_O <= req && !ACK_O;
      if (req && !ACK_O) begin
        DAT_O <= rdata;
      end
      if (wr) begin
        case (ADR_I)
          REG_CTRL:  ctrl  <= DAT_I[3:0];
          REG_FILT:  begin
            dc_filt  <= dc_wr;
            cnt_filt <= DAT_I[15:8];
          end
          REG_TFILT: begin
            dc_tfilt  <= dc_wr;
            cnt_tfilt <= DAT_I[15:8];
          end
          REG_CAPEN: capen <= DAT_I;
          REG_CNTEN: cnten <= DAT_I;
          REG_TAGEN: tagen <= DAT_I;
          REG_PSEL:  psel  <= DAT_I;
          REG_PVAL:  pval  <= DAT_I;
          REG_MASK:  mask  <= DAT_I;
          default:   ctrl  <= ctrl;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Scan view, events and status
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      cap_pend          <= '0;
      cap_val           <= '0;
      hold_last_reading <= '0;
      APP_VALUE         <= '0;
      EVENT_TRIG        <= '0;
      tag_pend          <= '0;
      TAG_VALID         <= 1'b0;
      TAG_CHAN          <= 5'h0;
      TAG_LEVEL         <= 1'b0;
      TAG_TIME          <= 32'h0;
      ERR_LED           <= 1'b0;
      FAIL_STAT         <= 1'b0;
      CH_LED            <= '0;
      POWER_DOWN        <= 1'b0;
    end else begin
      cap_pend <= next_cap_set | (cap_pend & ~{NCH{scan_rd}});
      cap_val  <= (next_cap_set & level) | (~next_cap_set & cap_val);
      if (!failed) begin
        hold_last_reading <= norm_view;
      end
      APP_VALUE  <= next_app;
      EVENT_TRIG <= chg & ch_ok;
      tag_pend   <= next_tag_set | (tag_pend & ~grant);
      TAG_VALID  <= |grant;
      if (|grant) begin
        TAG_CHAN  <= grant_idx;
        TAG_LEVEL <= level[grant_idx];
        TAG_TIME  <= ms_time;
      end
      ERR_LED    <= failed;
      FAIL_STAT  <= failed;
      CH_LED     <= level & ch_ok;
      POWER_DOWN <= sleep;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence bus_req_s;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence bus_ack_s;
    ACK_O ##1 !ACK_O;
  endsequence
  bus_answer_a: assert property (@(posedge CLK) disable iff (RST)
    bus_req_s |=> bus_ack_s)
    else $error("bus answer not one cycle after request");
  err_led_a: assert property (@(posedge CLK) disable iff (RST)
    ERR_LED == $past(|MOD_ERR))
    else $error("fault indicator disagrees with errors");
  sleep_pdv_a: assert property (@(posedge CLK) disable iff (RST)
    $past(sleep) |-> APP_VALUE == $past(pval))
    else $error("sleep not presenting presets");
  mask_pdv_a: assert property (@(posedge CLK) disable iff (RST)
    $past(!force_pdv && !failed) |->
      (APP_VALUE & $past(mask)) == ($past(pval) & $past(mask)))
    else $error("masked channel not showing preset");
  cap_keep_a: assert property (@(posedge CLK) disable iff (RST)
    $past(chg & cap_act) != 0 |-> (cap_pend & $past(chg & cap_act)) != 0)
    else $error("capture change lost");
  ac_nocap_a: assert property (@(posedge CLK) disable iff (RST)
    ac_mode |-> cap_act == 0 && cnt_act == 0)
    else $error("capture or counter active in AC mode");
  cnt_limit_a: assert property (@(posedge CLK) disable iff (RST)
    (cnt_act & ~cnt_ok) == 0)
    else $error("counter on disallowed channel");
  led_level_a: assert property (@(posedge CLK) disable iff (RST)
    CH_LED == $past(level & ch_ok))
    else $error("channel indicator wrong");
endmodule

// ---- dic_pkg.sv ----
// Purpose: Constants for the digital input conditioner
// Assumes: 25 MHz clock, classic Wishbone register access
// Notes:   Word-aligned byte offsets
//
// Contract
// - One per-module AC/DC choice, DC by default; IEC variant is DC only.
// - AC operation disables first-change capture, counters and all filtering.
// - DC capture channel reports first change since previous scan.
// - Non-capture channel reports present filtered level; short pulses lost.
// - Input filter 0..254 steps of 0.2 ms, default 50.
// - Counter filter 0..255 steps of 0.05 ms, default 20.
// - 32-channel model counts on first 20 channels; 16-channel on all.
// - Every channel raises an event trigger independent of the scan.
// - Tagged channel emits time-stamped record on each change; processor stores it.
// - On failure each channel shows last valid value or preset.
// - Masked channel shows preset value even in normal operation.
// - Sleep stops the module, cuts power, presents preset values.
// - Freeze presents presets while actual inputs stay observable.
// - Failure lights fault indicator and exposes failure flag.
// - Capture is per channel, off by default, DC only.
// - Test session uses temporary filter settings only while active.
// - Fault indicator stays lit while any error remains.
// - Channel indicator lit while the input is ON.
package dic_pkg;
  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int NCH          = 32;
  localparam int NCH_SMALL    = 16;
  localparam int CNT_CH_LARGE = 20;
  localparam int CLK_HZ       = 25_000_000;
  localparam int DC_UNIT_US   = 200;
  localparam int CNT_UNIT_US  = 50;
  localparam int MS_UNIT_US   = 1000;
  localparam int DC_UNIT_CYC  = CLK_HZ / 1_000_000 * DC_UNIT_US;
  localparam int CNT_UNIT_CYC = CLK_HZ / 1_000_000 * CNT_UNIT_US;
  localparam int MS_CYC       = CLK_HZ / 1_000_000 * MS_UNIT_US;
  localparam int DIV_W        = 15;
  localparam int CNT_W        = 16;

  // ----------------------------------------
  // Filter settings
  // ----------------------------------------
  localparam logic [7:0] DC_FILT_RST  = 8'h32;
  localparam logic [7:0] CNT_FILT_RST = 8'h14;
  localparam logic [7:0] DC_FILT_MAX  = 8'hFE;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FILT   = 8'h04;
  localparam logic [7:0] REG_CAPEN  = 8'h08;
  localparam logic [7:0] REG_CNTEN  = 8'h0C;
  localparam logic [7:0] REG_TAGEN  = 8'h10;
  localparam logic [7:0] REG_PSEL   = 8'h14;
  localparam logic [7:0] REG_PVAL   = 8'h18;
  localparam logic [7:0] REG_MASK   = 8'h1C;
  localparam logic [7:0] REG_SCAN   = 8'h20;
  localparam logic [7:0] REG_LIVE   = 8'h24;
  localparam logic [7:0] REG_STAT   = 8'h28;
  localparam logic [7:0] REG_TFILT  = 8'h2C;
  localparam logic [1:0] CNT_REGION = 2'h1;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_AC     = 0;
  localparam int CTRL_SLEEP  = 1;
  localparam int CTRL_FREEZE = 2;
  localparam int CTRL_TEST   = 3;
  localparam int FILT_DC_LSB  = 0;
  localparam int FILT_CNT_LSB = 8;
endpackage

// ---- dic_chan.sv ----
// Purpose: One input channel: synchroniser, debounce filter, counter
// Assumes: Ticks are one-cycle pulses at the filter unit rate
// Notes:   Holds level, filter count and counter while run is low; synchroniser keeps sampling
`timescale 1ns/1ps
module dic_chan
  import dic_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             raw_pin,
  input  wire logic             run,
  input  wire logic             bypass,
  input  wire logic             cnt_mode,
  input  wire logic             tick_dc,
  input  wire logic             tick_cnt,
  input  wire logic [7:0]       dc_lim,
  input  wire logic [7:0]       cnt_lim,
  output logic                  level,
  output logic                  chg,
  output logic [CNT_W-1:0]      count
);
  logic [2:0] sync;
  logic       samp;
  logic [7:0] held;
  logic       next_level;
  logic [7:0] next_held;

  wire       agree = sync[1] == sync[2];
  wire [7:0] lim   = cnt_mode ? cnt_lim : dc_lim;
  wire       tick  = cnt_mode ? tick_cnt : tick_dc;
  wire       unfilt = bypass || lim == 8'h00;

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  always_comb begin
    next_level = level;
    next_held  = held;
    if (!run) begin
      next_held = held;
    end else if (unfilt) begin
      next_level = samp;
      next_held  = 8'h00;
    end else if (samp == level) begin
      next_held = 8'h00;
    end else if (tick) begin
      if (held + 8'h01 >= lim) begin
        next_level = samp;
        next_held  = 8'h00;
      end else begin
        next_held = held + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync  <= 3'h0;
      samp  <= 1'b0;
      level <= 1'b0;
      held  <= 8'h00;
      chg   <= 1'b0;
      count <= '0;
    end else begin
      sync  <= {sync[1:0], raw_pin};
      if (agree) begin
        samp <= sync[2];
      end
      level <= next_level;
      held  <= next_held;
      chg   <= next_level != level;
      if (cnt_mode && !bypass && next_level && !level) begin
        count <= count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  filt_follow_a: assert property (@(posedge clk) disable iff (rst)
    level != $past(level) |-> level == $past(samp))
    else $error("level moved away from sampled input");
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    (level && !$past(level) && $past(cnt_mode) && !$past(bypass))
      |-> count == $past(count) + 16'h0001)
    else $error("counter missed a rising edge");
  run_hold_a: assert property (@(posedge clk) disable iff (rst)
    !$past(run) |-> level == $past(level))
    else $error("level changed while stopped");
endmodule

// ---- dic_cpu_model.sv ----
// Purpose: Processor model: bus master and event record store
// Assumes: Slave answers each request with one ack pulse
// Notes:   Bench calls access() for every register cycle
`timescale 1ns/1ps
module dic_cpu_model (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [3:0]       sel,
  output logic [7:0]       adr,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack,
  input  wire logic        tag_valid,
  input  wire logic [4:0]  tag_chan,
  input  wire logic        tag_level,
  input  wire logic        fail_stat
);
  int         rec_n = 0;
  logic [5:0] rec_last = 6'h00;
  logic       fail_log = 1'b0;

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hF;
    adr = 8'h00;
    dat_w = 32'h0000_0000;
  end

  // ----------------------------------------
  // Single classic cycle
  // ----------------------------------------
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat_w <= ~d;
  endtask

  always @(posedge clk) begin
    if (tag_valid === 1'b1) begin
      rec_n <= rec_n + 1;
      rec_last <= {tag_chan, tag_level};
    end
    if (fail_stat === 1'b1) begin
      fail_log <= 1'b1;
    end
  end
endmodule

// ---- test_digital_input_conditioner.sv ----
// Purpose: Self-checking bench for the input conditioner
// Assumes: Short filter tick (8 cycles) and ms tick (16 cycles)
// Notes:   One task per scenario
`timescale 1ns/1ps
module test_digital_input_conditioner
  import dic_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, err_led, fail_stat, tag_valid, tag_level, power_down;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] dat_w, dat_r, ch_led, app_value, event_trig, tag_time;
  logic [31:0] inp = 32'h0000_0000;
  logic [3:0]  mod_err = 4'h0;
  logic [4:0]  tag_chan;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          ev_cnt = 0;
  int          cyc_n = 0;
  int          tag_cyc = 0;
  logic [31:0] tag_seen = 32'h0000_0000;

  dic_top #(.DC_CYC(8), .MS_TICK(16), .MODEL_32(1'b1), .IEC_TYPE(1'b0)) dut_u (
    .CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .WE_I(we),
    .SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .INPUT_CHANNEL(inp),
    .MOD_ERR(mod_err), .ERR_LED(err_led), .FAIL_STAT(fail_stat), .CH_LED(ch_led),
    .APP_VALUE(app_value), .EVENT_TRIG(event_trig), .TAG_VALID(tag_valid),
    .TAG_CHAN(tag_chan), .TAG_LEVEL(tag_level), .TAG_TIME(tag_time),
    .POWER_DOWN(power_down));

  dic_cpu_model cpu_u (
    .clk(clk), .cyc(cyc), .stb(stb), .we(we), .sel(sel), .adr(adr), .dat_w(dat_w),
    .dat_r(dat_r), .ack(ack), .tag_valid(tag_valid), .tag_chan(tag_chan),
    .tag_level(tag_level), .fail_stat(fail_stat));

  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rst === 1'b0) begin
      cyc_n <= cyc_n + 1;
    end
    if (event_trig[2] === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
    end
    if (tag_valid === 1'b1) begin
      tag_cyc  <= cyc_n;
      tag_seen <= tag_time;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    cpu_u.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    cpu_u.access(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0]  a [8] = '{REG_CTRL, REG_FILT, REG_CAPEN, REG_CNTEN, REG_TAGEN,
                           REG_PSEL, REG_MASK, 8'h30};
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      rd(a[i], q);
      chk("reset reg", q, (i == 1) ? 32'h0000_1432 : 32'h0000_0000);
    end
    wr(REG_FILT, 32'h0000_14FF);
    rd(REG_FILT, q);
    chk("filt clamp", q, 32'h0000_14FE);
    $display("test reset done");
  endtask

  task automatic t_filter();
    wr(REG_FILT, 32'h0000_1404);
    inp[0] <= 1'b1;
    idle(20);
    chk("led0 early", 32'(ch_led[0]), 32'h0);
    idle(40);
    chk("led0 late", 32'(ch_led[0]), 32'h1);
    inp[1] <= 1'b1;
    idle(6);
    inp[1] <= 1'b0;
    idle(60);
    chk("glitch", 32'(app_value[1:0]), 32'h1);
    $display("test filter done");
  endtask

  task automatic t_capture();
    logic [31:0] q;
    int          e0;
    wr(REG_FILT, 32'h0000_1400);
    wr(REG_CAPEN, 32'h0000_0002);
    e0 = ev_cnt;
    inp[2:1] <= 2'b11;
    idle(8);
    inp[2:1] <= 2'b00;
    idle(10);
    rd(REG_SCAN, q);
    chk("scan cap", 32'(q[2:1]), 32'h1);
    rd(REG_SCAN, q);
    chk("scan clr", 32'(q[1]), 32'h0);
    chk("events", 32'(ev_cnt - e0), 32'h2);
    $display("test capture done");
  endtask

  task automatic t_ac();
    logic [31:0] q;
    wr(REG_FILT, 32'h0000_14FE);
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_CNTEN, 32'h0000_0001);
    inp[3] <= 1'b1;
    inp[1:0] <= 2'b10;
    idle(6);
    inp[1:0] <= 2'b01;
    idle(6);
    chk("ac nofilt", 32'(ch_led[3]), 32'h1);
    rd(REG_SCAN, q);
    chk("ac nocap", 32'(q[1]), 32'h0);
    rd(8'h40, q);
    chk("ac nocnt", q, 32'h0);
    inp[0] <= 1'b0;
    wr(REG_CTRL, 32'h0000_0000);
    $display("test ac done");
  endtask

  task automatic t_count();
    logic [31:0] q;
    wr(REG_FILT, 32'h0000_0000);
    wr(REG_CNTEN, 32'h0018_0001);
    for (int i = 0; i < 3; i++) begin
      inp[20:19] <= 2'b11;
      inp[0] <= 1'b1;
      idle(4);
      inp[20:19] <= 2'b00;
      inp[0] <= 1'b0;
      idle(4);
    end
    idle(6);
    rd(8'h40, q);
    chk("cnt0", q, 32'h3);
    rd(8'h8C, q);
    chk("cnt19", q, 32'h3);
    rd(8'h90, q);
    chk("cnt20", q, 32'h0);
    $display("test count done");
  endtask

  task automatic t_subst();
    logic [31:0] q;
    wr(REG_PVAL, 32'h0000_0020);
    wr(REG_MASK, 32'h0000_0020);
    idle(3);
    chk("mask", 32'(app_value[5]), 32'h1);
    chk("leds", ch_led, inp);
    wr(REG_MASK, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0004);
    idle(3);
    chk("freeze app", app_value, 32'h0000_0020);
    rd(REG_LIVE, q);
    chk("freeze live", q, inp);
    wr(REG_CTRL, 32'h0000_0002);
    idle(3);
    chk("sleep app", app_value, 32'h0000_0020);
    chk("sleep pwr", 32'(power_down), 32'h1);
    wr(REG_CTRL, 32'h0000_0000);
    idle(2);
    chk("wake pwr", 32'(power_down), 32'h0);
    $display("test substitute done");
  endtask

  task automatic t_fail();
    logic [31:0] q;
    wr(REG_PVAL, 32'h0000_0000);
    wr(REG_PSEL, 32'h0000_0080);
    inp[7:6] <= 2'b11;
    idle(8);
    mod_err <= 4'h1;
    idle(3);
    chk("fail flags", {30'h0, err_led, fail_stat}, 32'h3);
    inp[6] <= 1'b0;
    idle(8);
    chk("fail app", 32'(app_value[7:6]), 32'h1);
    rd(REG_STAT, q);
    chk("stat", q, 32'h3);
    mod_err <= 4'h2;
    idle(3);
    chk("led held", 32'(err_led), 32'h1);
    mod_err <= 4'h0;
    idle(3);
    chk("led off", 32'(err_led), 32'h0);
    chk("fail log", 32'(cpu_u.fail_log), 32'h1);
    $display("test failure done");
  endtask

  task automatic t_tag();
    int n0;
    n0 = cpu_u.rec_n;
    wr(REG_TAGEN, 32'h0000_0010);
    inp[4] <= 1'b1;
    inp[9] <= 1'b1;
    idle(12);
    chk("tag count", 32'(cpu_u.rec_n - n0), 32'h1);
    chk("tag rec", 32'(cpu_u.rec_last), 32'h9);
    chk("tag time", tag_seen, 32'((tag_cyc - 1) / 16));
    $display("test tag done");
  endtask

  task automatic t_testfilt();
    wr(REG_FILT, 32'h0000_00FE);
    wr(REG_TFILT, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0008);
    inp[8] <= 1'b1;
    idle(10);
    chk("test filt", 32'(ch_led[8]), 32'h1);
    wr(REG_CTRL, 32'h0000_0000);
    inp[8] <= 1'b0;
    idle(40);
    chk("normal filt", 32'(ch_led[8]), 32'h1);
    $display("test test-filter done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_filter();
    t_capture();
    t_ac();
    t_count();
    t_subst();
    t_fail();
    t_tag();
    t_testfilt();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
